// file: gpp_port.sv
// General port block: CMOS port, open-drain port, analog input port, output pin
//
// Operation
// - Per-bit direction on every bidirectional port
// - Software pull-up enable per CMOS pin
// - Open-drain port only pulls low, per-bit direction
// - Open-drain pull-ups fixed by manufacturing option
// - CMOS port pins can carry alternate peripheral functions
// - Reset puts bidirectional ports in input mode
// - Analog-shared port is input only
// - Output-only pin low during reset
`timescale 1ns/1ps
`default_nettype none
`include "gpp_regs.svh"
module gpp_port #(
	parameter int         CW         = `GPP_CMOS_W,
	parameter int         OW         = `GPP_OD_W,
	parameter int         AW         = `GPP_AN_W,
	parameter logic [3:0] OD_PULL_OPT = 4'h0   // Manufacturing pull-up option
) (
	input  wire logic          ref_clk,
	input  wire logic          rst,
	// Wishbone slave
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [7:0]    wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic      [31:0]   wb_dat_o,
	output logic               wb_ack_o,
	// CMOS bidirectional port
	input  wire logic [CW-1:0] cmosPinIn,
	output logic      [CW-1:0] cmosPinOut,
	output logic      [CW-1:0] cmosPinOe,
	output logic      [CW-1:0] cmosPullupEn,
	// Alternate function path for the CMOS port
	input  wire logic [CW-1:0] altOut,
	input  wire logic [CW-1:0] altOe,
	output logic      [CW-1:0] altIn,
	// Open-drain port pins
	input  wire logic [OW-1:0] openDrainPortPinsIn,
	output logic      [OW-1:0] openDrainPortPinsOut,
	output logic      [OW-1:0] openDrainPortPinsOe,
	output logic      [OW-1:0] openDrainPullupFitted,
	// Analog-shared input pins
	input  wire logic [AW-1:0] analogSharedInputPins,
	output logic      [AW-1:0] analogInputs,
	// Output-only pin
	output logic               outputOnlyPin
);
	// ****************************************
	// Storage
	// ****************************************
	logic [CW-1:0] cmosLatch_reg;   // CMOS output latch
	logic [CW-1:0] cmosDir_reg;     // 1 = input
	logic [CW-1:0] cmosPull_reg;    // Pull-up enables
	logic [CW-1:0] cmosAlt_reg;     // Alternate function select
	logic [OW-1:0] odLatch_reg;     // Open-drain latch
	logic [OW-1:0] odDir_reg;       // 1 = input
	logic          outPin_reg;      // Output-only latch
	logic [CW-1:0] cmosSync;        // Synchronised pins
	logic [OW-1:0] odSync;
	logic [AW-1:0] anSync;
	gpp_pkg::gpp_bus_t busState_reg;
	logic          busReq;
	logic          wrEn;
	logic [31:0]   rdData_next;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	gpp_sync #(.W(CW)) uSyncCmos (
		.ref_clk (ref_clk),
		.rst     (rst),
		.asyncIn (cmosPinIn),
		.syncOut (cmosSync)
	);
	gpp_sync #(.W(OW)) uSyncOd (
		.ref_clk (ref_clk),
		.rst     (rst),
		.asyncIn (openDrainPortPinsIn),
		.syncOut (odSync)
	);
	gpp_sync #(.W(AW)) uSyncAn (
		.ref_clk (ref_clk),
		.rst     (rst),
		.asyncIn (analogSharedInputPins),
		.syncOut (anSync)
	);

	// ****************************************
	// Wishbone handshake
	// ****************************************
	assign busReq = wb_cyc_i && wb_stb_i && (busState_reg == gpp_pkg::GPP_IDLE);
	assign wrEn   = busReq && wb_we_i && wb_sel_i[0];

	// Ack one cycle after request, dropped next cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			busState_reg <= gpp_pkg::GPP_IDLE;
		end else begin
			case (busState_reg)
				gpp_pkg::GPP_IDLE: begin
					if (busReq) begin
						busState_reg <= gpp_pkg::GPP_ACK;
					end
				end
				gpp_pkg::GPP_ACK: begin
					busState_reg <= gpp_pkg::GPP_IDLE;
				end
				default: begin
					busState_reg <= gpp_pkg::GPP_IDLE;
				end
			endcase
		end
	end
	assign wb_ack_o = (busState_reg == gpp_pkg::GPP_ACK);

	// ****************************************
	// Register writes
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cmosLatch_reg <= '0;
			cmosDir_reg   <= `GPP_DIR_RST;      // All inputs
			cmosPull_reg  <= '0;
			cmosAlt_reg   <= '0;
			odLatch_reg   <= '0;
			odDir_reg     <= `GPP_DIR_OD_RST;   // All inputs
		end else if (wrEn) begin
			case (wb_adr_i)
				`GPP_DATA_CMOS_OFS: cmosLatch_reg <= wb_dat_i[CW-1:0];
				`GPP_DIR_CMOS_OFS:  cmosDir_reg   <= wb_dat_i[CW-1:0];
				`GPP_PULL_CMOS_OFS: cmosPull_reg  <= wb_dat_i[CW-1:0];
				`GPP_ALT_CMOS_OFS:  cmosAlt_reg   <= wb_dat_i[CW-1:0];
				`GPP_DATA_OD_OFS:   odLatch_reg   <= wb_dat_i[OW-1:0];
				`GPP_DIR_OD_OFS:    odDir_reg     <= wb_dat_i[OW-1:0];
				default: begin
				end
			endcase
		end
	end

	// Output-only pin latch, low under reset
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			outPin_reg <= `GPP_OUTPIN_RST;
		end else if (wrEn && wb_adr_i == `GPP_OUTPIN_OFS) begin
			outPin_reg <= wb_dat_i[0];
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	always_comb begin
		rdData_next = 32'h0000_0000;
		case (wb_adr_i)
			// Latch for outputs, pin for inputs
			`GPP_DATA_CMOS_OFS: rdData_next[CW-1:0] =
				(cmosDir_reg & cmosSync) | (~cmosDir_reg & cmosLatch_reg);
			`GPP_DIR_CMOS_OFS:  rdData_next[CW-1:0] = cmosDir_reg;
			`GPP_PULL_CMOS_OFS: rdData_next[CW-1:0] = cmosPull_reg;
			`GPP_ALT_CMOS_OFS:  rdData_next[CW-1:0] = cmosAlt_reg;
			`GPP_DATA_OD_OFS:   rdData_next[OW-1:0] =
				(odDir_reg & odSync) | (~odDir_reg & odLatch_reg);
			`GPP_DIR_OD_OFS:    rdData_next[OW-1:0] = odDir_reg;
			`GPP_ANALOG_OFS:    rdData_next[AW-1:0] = anSync;
			`GPP_OUTPIN_OFS:    rdData_next[0]      = outPin_reg;
			`GPP_MASKOPT_OFS:   rdData_next[3:0]    = OD_PULL_OPT;
			default:            rdData_next         = 32'h0000_0000;
		endcase
	end

	// Read data captured with the request
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (busReq && !wb_we_i) begin
			wb_dat_o <= rdData_next;
		end
	end

	// ****************************************
	// Pin drive
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cmosPinOut            <= '0;
			cmosPinOe             <= '0;
			cmosPullupEn          <= '0;
			openDrainPortPinsOut  <= '0;
			openDrainPortPinsOe   <= '0;
			outputOnlyPin         <= 1'b0;
		end else begin
			// Alternate function overrides latch and direction
			cmosPinOut   <= (cmosAlt_reg & altOut) | (~cmosAlt_reg & cmosLatch_reg);
			cmosPinOe    <= (cmosAlt_reg & altOe) | (~cmosAlt_reg & ~cmosDir_reg);
			// Pull-up only while pin is an input
			cmosPullupEn <= cmosPull_reg & ~((cmosAlt_reg & altOe) | (~cmosAlt_reg & ~cmosDir_reg));
			// Drive low only, never high
			openDrainPortPinsOut <= '0;
			openDrainPortPinsOe  <= ~odDir_reg & ~odLatch_reg;
			outputOnlyPin        <= outPin_reg;
		end
	end

	// Fixed pull-up option, no software path
	assign openDrainPullupFitted = OD_PULL_OPT;
	// Peripheral view of pins
	assign altIn        = cmosSync;
	assign analogInputs = anSync;

	// ****************************************
	// Assertions
	// ****************************************
	sequence dirWrite_s;
		wrEn && wb_adr_i == `GPP_DIR_CMOS_OFS;
	endsequence

	dir_bitwise_a: assert property (@(posedge ref_clk) disable iff (rst)
		dirWrite_s ##1 (cmosAlt_reg == 8'h00) |=> (cmosPinOe == ~cmosDir_reg))
		else $error("CMOS enables do not follow direction");
	// Pull-up follows its enable on input pins only
	pull_input_a: assert property (@(posedge ref_clk) disable iff (rst)
		(cmosAlt_reg == 8'h00)
		|=> (cmosPullupEn == ($past(cmosPull_reg) & $past(cmosDir_reg))))
		else $error("Pull-up does not follow enable on inputs");
	od_nohigh_a: assert property (@(posedge ref_clk) disable iff (rst)
		openDrainPortPinsOut == 4'h0)
		else $error("Open-drain pin driven high");
	od_dir_a: assert property (@(posedge ref_clk) disable iff (rst)
		(odDir_reg == 4'hF) |=> (openDrainPortPinsOe == 4'h0))
		else $error("Open-drain input pin driven");
	// Option reads back fixed, whatever software wrote
	od_option_a: assert property (@(posedge ref_clk) disable iff (rst)
		(busReq && !wb_we_i && wb_adr_i == `GPP_MASKOPT_OFS)
		|=> (wb_dat_o[3:0] == OD_PULL_OPT && openDrainPullupFitted == OD_PULL_OPT))
		else $error("Pull-up option not fixed");
	alt_route_a: assert property (@(posedge ref_clk) disable iff (rst)
		(cmosAlt_reg[0] && altOe[0]) |=> cmosPinOe[0])
		else $error("Alternate drive not routed");
	reset_input_a: assert property (@(posedge ref_clk)
		rst |=> (cmosPinOe == 8'h00 && openDrainPortPinsOe == 4'h0))
		else $error("Pins driven after reset");
	out_reset_a: assert property (@(posedge ref_clk)
		rst |=> !outputOnlyPin)
		else $error("Output pin high in reset");
	an_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		(busReq && !wb_we_i && wb_adr_i == `GPP_ANALOG_OFS) |=> wb_dat_o[7:0] == $past(anSync))
		else $error("Analog read mismatch");
	// Output bits of the open-drain port read back the latch
	od_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		(busReq && !wb_we_i && wb_adr_i == `GPP_DATA_OD_OFS)
		|=> (((wb_dat_o[3:0] ^ $past(odLatch_reg)) & ~$past(odDir_reg)) == 4'h0))
		else $error("Output port read not latch");
endmodule : gpp_port
`default_nettype wire

// file: gpp_regs.svh
// Register offsets, field widths and reset values of the general port block
`ifndef GPP_REGS_SVH
`define GPP_REGS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define GPP_DATA_CMOS_OFS   8'h00
`define GPP_DIR_CMOS_OFS    8'h04
`define GPP_PULL_CMOS_OFS   8'h08
`define GPP_ALT_CMOS_OFS    8'h0C
`define GPP_DATA_OD_OFS     8'h10
`define GPP_DIR_OD_OFS      8'h14
`define GPP_ANALOG_OFS      8'h18
`define GPP_OUTPIN_OFS      8'h1C
`define GPP_MASKOPT_OFS     8'h20

// ****************************************
// Widths and reset values
// ****************************************
`define GPP_CMOS_W          8
`define GPP_OD_W            4
`define GPP_AN_W            8
`define GPP_DIR_RST         8'hFF
`define GPP_DIR_OD_RST      4'hF
`define GPP_OUTPIN_RST      1'h0

`endif

// file: gpp_pkg.sv
// Types shared by the general port block
`default_nettype none
package gpp_pkg;
	// Bus slave phases
	typedef enum logic [1:0] {
		GPP_IDLE = 2'b01,
		GPP_ACK  = 2'b10
	} gpp_bus_t;
endpackage : gpp_pkg
`default_nettype wire

// file: gpp_sync.sv
// Two-stage synchroniser for a bank of pin inputs
`timescale 1ns/1ps
`default_nettype none
module gpp_sync #(
	parameter int W = 8
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);
	// First stage, read only by the second
	logic [W-1:0] stage1_reg;

	// ****************************************
	// Synchroniser stages
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stage1_reg <= '0;
			syncOut    <= '0;
		end else begin
			stage1_reg <= asyncIn;
			syncOut    <= stage1_reg;
		end
	end
endmodule : gpp_sync
`default_nettype wire

// file: gpp_pin_model.sv
// Board-side model of the port pins
`timescale 1ns/1ps
`default_nettype none
module gpp_pin_model (
	input  wire logic [7:0] pinOut,
	input  wire logic [7:0] pinOe,
	input  wire logic [7:0] pullEn,
	input  wire logic [7:0] extLevel,
	input  wire logic [3:0] odOe,
	input  wire logic [3:0] odFitted,
	input  wire logic [3:0] odExt,
	output logic      [7:0] cmosLevel,
	output logic      [3:0] odLevel
);
	// Driver wins, then pull-up, then board level
	assign cmosLevel = (pinOe & pinOut) | (~pinOe & pullEn) | (~pinOe & ~pullEn & extLevel);
	// Open drain only pulls low; fitted pull-up else board
	assign odLevel = ~odOe & (odFitted | odExt);
endmodule : gpp_pin_model
`default_nettype wire

// file: gpp_port_tb.sv
// Self-checking bench for the general port block
`timescale 1ns/1ps
`default_nettype none
`include "gpp_regs.svh"
module gpp_port_tb;
	// ****
	// Signals
	// ****
	logic        ref_clk = 1'b0, rst = 1'b1;
	logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
	logic [7:0]  wbAdr = 8'h00;
	logic [3:0]  wbSel = 4'h0;
	logic [31:0] wbDatW = 32'h0, wbDatR, rd;
	logic        wbAck, outPin;
	logic [7:0]  pOut, pOe, pPull, pLvl, ext = 8'h0F, altO = 8'h00, altE = 8'h00, altI;
	logic [7:0]  anPins = 8'h00, anSync;
	logic [3:0]  odOut, odOe, odFit, odLvl;
	int          errCount = 0, nChecks = 0;
	always #12.5 ref_clk = ~ref_clk;  // 40 MHz
	gpp_port #(.OD_PULL_OPT(4'h9)) gpp_port_i (.ref_clk(ref_clk), .rst(rst),
		.wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
		.wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
		.cmosPinIn(pLvl), .cmosPinOut(pOut), .cmosPinOe(pOe), .cmosPullupEn(pPull),
		.altOut(altO), .altOe(altE), .altIn(altI), .openDrainPortPinsIn(odLvl),
		.openDrainPortPinsOut(odOut), .openDrainPortPinsOe(odOe),
		.openDrainPullupFitted(odFit), .analogSharedInputPins(anPins),
		.analogInputs(anSync), .outputOnlyPin(outPin));
	gpp_pin_model gpp_pin_model_i (.pinOut(pOut), .pinOe(pOe), .pullEn(pPull),
		.extLevel(ext), .odOe(odOe), .odFitted(odFit), .odExt(4'h0),
		.cmosLevel(pLvl), .odLevel(odLvl));
	// ****
	// Tasks
	// ****
	// Compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			errCount++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One classic Wishbone cycle, waits for ack
	task automatic wbXfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s);
		wbCyc  <= 1'b1;
		wbStb  <= 1'b1;
		wbWe   <= w;
		wbAdr  <= a;
		wbSel  <= s;
		wbDatW <= d;
		// Wait for ack; only the watchdog ends a hung wait
		do begin
			@(posedge ref_clk);
		end while (wbAck !== 1'b1);
		rd = wbDatR;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge ref_clk);
		// Ack lasts one cycle only
		chk({31'h0, wbAck}, 32'h0);
	endtask : wbXfer
	// Write one register, all byte lanes enabled
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wbXfer(1'b1, a, d, 4'hF);
	endtask : wr
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		wbXfer(1'b0, a, 32'h0, 4'h0);
		chk(rd, e);
	endtask : rdChk
	// Verdict and end of run
	task automatic tallyAndFinish();
		$display("checks=%0d mismatches=%0d", nChecks, errCount);
		if (errCount == 0 && nChecks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : tallyAndFinish
	// ****
	// Watchdog
	// ****
	initial begin
		repeat (5000) @(posedge ref_clk);
		errCount++;
		tallyAndFinish();
	end
	// ****
	// Tests
	// ****
	initial begin
		repeat (4) @(posedge ref_clk);
		chk({16'h0, pOe, 3'h0, odOe, outPin}, 32'h0);
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rdChk(`GPP_DIR_CMOS_OFS, 32'hFF);
		rdChk(`GPP_DIR_OD_OFS, 32'hF);
		$display("reset test done");
		wr(`GPP_DIR_CMOS_OFS, 32'hA5);
		wr(`GPP_DATA_CMOS_OFS, 32'h3C);
		chk({16'h0, pOe, pOut & pOe}, 32'h5A18);
		repeat (3) @(posedge ref_clk);
		rdChk(`GPP_DATA_CMOS_OFS, 32'h1D);
		wbXfer(1'b1, `GPP_DATA_CMOS_OFS, 32'hFF, 4'hE);
		rdChk(`GPP_DATA_CMOS_OFS, 32'h1D);
		$display("direction test done");
		wr(`GPP_PULL_CMOS_OFS, 32'hF0);
		chk({24'h0, pPull}, 32'hA0);
		ext <= 8'h00;
		repeat (3) @(posedge ref_clk);
		rdChk(`GPP_DATA_CMOS_OFS, 32'hB8);
		$display("pull-up test done");
		wr(`GPP_DIR_OD_OFS, 32'h5);
		wr(`GPP_DATA_OD_OFS, 32'h2);
		chk({20'h0, odOe, odOut, odFit}, 32'h809);
		repeat (3) @(posedge ref_clk);
		rdChk(`GPP_DATA_OD_OFS, 32'h3);
		wr(`GPP_MASKOPT_OFS, 32'h6);
		rdChk(`GPP_MASKOPT_OFS, 32'h9);
		$display("open-drain test done");
		anPins <= 8'h5A;
		repeat (3) @(posedge ref_clk);
		wr(`GPP_ANALOG_OFS, 32'hFF);
		rdChk(`GPP_ANALOG_OFS, 32'h5A);
		chk({24'h0, anSync}, 32'h5A);
		rdChk(8'h40, 32'h0);
		$display("analog test done");
		wr(`GPP_OUTPIN_OFS, 32'h1);
		chk({31'h0, outPin}, 32'h1);
		rdChk(`GPP_OUTPIN_OFS, 32'h1);
		$display("output pin test done");
		altO <= 8'h01;
		altE <= 8'h03;
		wr(`GPP_ALT_CMOS_OFS, 32'h03);
		chk({16'h0, pOe, pOut & pOe}, 32'h5B19);
		repeat (3) @(posedge ref_clk);
		chk({24'h0, altI}, 32'hB9);
		$display("alternate test done");
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk({16'h0, pOe, 3'h0, odOe, outPin}, 32'h0);
		// Release again: registers must be back at their reset values
		rst <= 1'b0;
		@(posedge ref_clk);
		rdChk(`GPP_DIR_CMOS_OFS, 32'hFF);
		rdChk(`GPP_OUTPIN_OFS, 32'h0);
		$display("second reset test done");
		tallyAndFinish();
	end
endmodule : gpp_port_tb
`default_nettype wire
